// *** rtl/qmode_pkg.sv ***
// Constants, register map and carrier types for the command-mode and
// soft-reset interpreter. Assumes a 100 MHz clock and an APB register bus.
package qmode_pkg;
    // ========================================================
    // Opcodes
    localparam logic [7:0] OP_ENTER_4L = 8'h38;
    localparam logic [7:0] OP_EXIT_4L  = 8'hFF;
    localparam logic [7:0] OP_ARM      = 8'h66;
    localparam logic [7:0] OP_EXEC     = 8'h99;

    // ========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CFG    = 8'h08;
    localparam logic [7:0] ADDR_VOL    = 8'h0C;

    // ========================================================
    // Field positions
    localparam int ST_FOURLINE = 0;
    localparam int ST_ARMED    = 1;
    localparam int ST_RECOVER  = 2;
    localparam int CFG_QE      = 0;

    // ========================================================
    // Timing: recovery after an accepted reset
    localparam int CLK_MHZ         = 100;
    localparam int RECOVER_US      = 30;
    localparam int RECOVER_CYCLES  = RECOVER_US * CLK_MHZ;
    localparam int RECOVER_W       = 12;

    // ========================================================
    // Volatile settings, restored to VOL_RESET by an accepted reset
    typedef struct packed {
        logic [7:0] volStatus;        // [31:24]
        logic [2:0] spare;            // [23:21] reads zero
        logic       suspendFlag;      // [20]
        logic       writeEnableLatch; // [19]
        logic [2:0] wrapSettingBits;  // [18:16]
        logic [7:0] contReadModeBits; // [15:8]
        logic [7:0] readParamBits;    // [7:0] P5:P4 dummy, P1:P0 wrap length
    } vol_t;

    // Dummy code 00 = 2 clocks, wrap code 00 = 8 bytes
    localparam vol_t VOL_RESET = '{volStatus: 8'h00, spare: 3'h0, suspendFlag: 1'b0,
                                   writeEnableLatch: 1'b0, wrapSettingBits: 3'h7,
                                   contReadModeBits: 8'h00, readParamBits: 8'h00};
endpackage : qmode_pkg

// *** rtl/recovery_timer.sv ***
// Recovery interval timer: a start pulse holds busy high for a fixed
// number of clock cycles. Assumes one synchronous clock domain.
`timescale 1ns/100ps
module recovery_timer (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic start,
    output logic      busy
);
    import qmode_pkg::*;

    localparam logic [RECOVER_W-1:0] LAST = RECOVER_W'(RECOVER_CYCLES - 1);

    logic [RECOVER_W-1:0] count_q, count_d;
    logic                 busy_q, busy_d;

    // ========================================================
    // Count down while busy
    always_comb begin
        count_d = count_q;
        busy_d  = busy_q;
        if (start) begin
            count_d = LAST;
            busy_d  = 1'b1;
        end else if (busy_q) begin
            if (count_q == '0) begin
                busy_d = 1'b0;
            end else begin
                count_d = count_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_q <= '0;
            busy_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q  <= busy_d;
        end
    end

    assign busy = busy_q;
endmodule : recovery_timer

// *** rtl/qmode_ctrl.sv ***
// Command interpreter for four-line mode entry/exit and the two-step
// soft reset, with an APB slave for opcodes and settings.
// Assumes a host that writes one opcode per write to the command register.
//
// Behaviour
// - Exit opcode leaves four-line mode
// - Mode switch keeps latch, suspend, wrap
// - Accepted reset aborts operations, restores defaults
// - Accepted reset clears all volatile settings (code loads VOL_RESET: wrap setting bits 111)
// - Arm and execute accepted in both modes
// - Reset only on arm then execute
// - Any other command disarms the reset
// - Commands ignored for 30 us after reset
// - Enter four-line mode only if quad enabled
// - Defaults: wrap 8 bytes, two dummy clocks
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module qmode_ctrl (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               fourLineMode,
    output logic               abortOps,
    output qmode_pkg::vol_t    volSettings
);
    import qmode_pkg::*;

    // Decode of a register address, used by read and write paths
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == ADDR_CMD) || (a == ADDR_STATUS) ||
                   (a == ADDR_CFG) || (a == ADDR_VOL);
    endfunction : isMapped

    logic        fourLine_q, fourLine_d;
    logic        armed_q, armed_d;
    logic        qe_q, qe_d;
    logic        abort_q, abort_d;
    logic [7:0]  lastOp_q, lastOp_d;
    vol_t        vol_q, vol_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        recBusy;
    logic        recovering;
    logic        wrEn;
    logic        cmdGo;
    logic [7:0]  op;

    recovery_timer u_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .start (abort_q),
        .busy  (recBusy)
    );

    // ========================================================
    // Bus qualifiers
    // Abort cycle counts as recovery so a write landing on it is dropped
    assign recovering = recBusy | abort_q;
    assign wrEn       = psel & penable & pready_q & pwrite & isMapped(paddr);
    assign cmdGo      = wrEn & (paddr == ADDR_CMD) & ~recovering;
    assign op         = pwdata[7:0];

    // ========================================================
    // Command decode and settings
    always_comb begin
        fourLine_d = fourLine_q;
        armed_d    = armed_q;
        qe_d       = qe_q;
        abort_d    = 1'b0;
        lastOp_d   = lastOp_q;
        vol_d      = vol_q;
        if (cmdGo) begin
            lastOp_d = op;
            armed_d  = 1'b0;
            case (op)
                OP_ENTER_4L: begin
                    if (qe_q) begin
                        fourLine_d = 1'b1;
                    end
                end
                // return to serial mode; settings untouched
                OP_EXIT_4L: begin
                    fourLine_d = 1'b0;
                end
                OP_ARM: begin
                    armed_d = 1'b1;
                end
                OP_EXEC: begin
                    abort_d = armed_q;
                end
                default: begin
                    armed_d = 1'b0;
                end
            endcase
        end else if (wrEn && !recovering) begin
            if (paddr == ADDR_CFG) begin
                qe_d = pwdata[CFG_QE];
            end else if (paddr == ADDR_VOL) begin
                vol_d       = vol_t'(pwdata);
                vol_d.spare = 3'h0;
            end
        end
        if (abort_d) begin
            fourLine_d = 1'b0;
            armed_d    = 1'b0;
            vol_d      = VOL_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fourLine_q <= 1'b0;
            armed_q    <= 1'b0;
            qe_q       <= 1'b0;
            abort_q    <= 1'b0;
            lastOp_q   <= 8'h00;
            vol_q      <= VOL_RESET;
        end else begin
            fourLine_q <= fourLine_d;
            armed_q    <= armed_d;
            qe_q       <= qe_d;
            abort_q    <= abort_d;
            lastOp_q   <= lastOp_d;
            vol_q      <= vol_d;
        end
    end

    // ========================================================
    // APB answer: data registered in setup, ready for one access cycle
    always_comb begin
        pready_d  = psel & ~penable;
        pslverr_d = psel & ~penable & ~isMapped(paddr);
        prdata_d  = prdata_q;
        if (psel && !penable) begin
            case (paddr)
                ADDR_CMD:    prdata_d = {24'h000000, lastOp_q};
                ADDR_STATUS: prdata_d = {29'h00000000, recovering, armed_q, fourLine_q};
                ADDR_CFG:    prdata_d = {31'h00000000, qe_q};
                ADDR_VOL:    prdata_d = 32'(vol_q);
                default:     prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign fourLineMode = fourLine_q;
    assign abortOps     = abort_q;
    assign volSettings  = vol_q;

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    localparam int REC_LEN = RECOVER_CYCLES;
    logic [RECOVER_W:0] recLen_q;
    // Helper: length of the last recovery burst
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            recLen_q <= '0;
        end else if (recBusy) begin
            recLen_q <= recLen_q + 1'b1;
        end else begin
            recLen_q <= '0;
        end
    end

    exit_mode_a: assert property (cmdGo && op == OP_EXIT_4L |=> !fourLine_q)
        else $error("exit opcode did not leave four-line mode");
    keep_latch_a: assert property ((cmdGo && (op == OP_EXIT_4L || op == OP_ENTER_4L))
        |=> vol_q == $past(vol_q))
        else $error("mode switch changed volatile settings");
    abort_pulse_a: assert property (cmdGo && op == OP_EXEC && armed_q
        |=> abortOps ##1 !abortOps ##1 recBusy)
        else $error("accepted reset did not abort for one cycle");
    clear_vol_a: assert property (abortOps |-> vol_q == VOL_RESET)
        else $error("volatile settings not cleared by reset");
    arm_any_a: assert property (cmdGo && op == OP_ARM |=> armed_q)
        else $error("arm opcode not accepted");
    exec_pair_a: assert property ($rose(abortOps) |-> $past(armed_q))
        else $error("reset without preceding arm");
    disarm_a: assert property (cmdGo && op != OP_ARM |=> !armed_q)
        else $error("reset state survived another command");
    rec_len_a: assert property ($fell(recBusy) |-> recLen_q == REC_LEN)
        else $error("recovery interval has wrong length");
    rec_ignore_a: assert property (recovering && wrEn && paddr == ADDR_CMD
        |=> $stable(lastOp_q) && !fourLine_q)
        else $error("command taken during recovery");
    enter_qe_a: assert property (cmdGo && op == OP_ENTER_4L && !fourLine_q
        |=> fourLine_q == $past(qe_q))
        else $error("entry not gated by quad enable");
    dflt_param_a: assert property (abortOps |-> vol_q.readParamBits[5:4] == 2'b00
        && vol_q.readParamBits[1:0] == 2'b00)
        else $error("default dummy or wrap length wrong");
    start_state_a: assert property (abortOps |-> !armed_q && !fourLine_q)
        else $error("reset left armed or four-line state");

    enter_c: cover property (cmdGo && op == OP_ENTER_4L && qe_q);
    reset_c: cover property (fourLine_q && cmdGo && op == OP_EXEC && armed_q);
    break_c: cover property (armed_q && cmdGo && op == OP_EXIT_4L);
    rec_end_c: cover property ($fell(recBusy));
endmodule : qmode_ctrl

// *** test/flash_host_model.sv ***
// Host-side model: one APB transfer for each go pulse from the bench.
// Assumes a slave on the same clock that raises pready when it answers.
`timescale 1ns/100ps
module flash_host_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        go,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic [31:0]      rdata,
    output logic             err,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ==========================================================
    // Transfer sequencing
    // one command per transfer
    always_ff @(posedge clk) begin
        done <= 1'b0;
        if (!rst_b) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 8'h00;
            pwdata  <= 32'h0;
            rdata   <= 32'h0;
            err     <= 1'b0;
        end else if (psel && penable && pready) begin
            rdata   <= prdata;
            err     <= pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            pwdata  <= ~pwdata; // Stale data must not look valid
            done    <= 1'b1;
        end else if (psel) begin
            penable <= 1'b1;
        end else if (go) begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= addr;
            pwdata <= wdata;
        end
    end
endmodule : flash_host_model

// *** test/quad_mode_exit_and_soft_reset_tb_top.sv ***
// Bench for the command interpreter: mode switching and soft reset.
// Assumes the host model above and a one-wait-free APB slave.
`timescale 1ns/100ps
module quad_mode_exit_and_soft_reset_tb_top;
    import qmode_pkg::*;
    localparam int PUW_CYCLES = 100; // Scaled power-up write delay
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        go = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        done, err, psel, penable, pwrite, pready, pslverr, fourLineMode, abortOps;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    vol_t        volSettings;
    int          nErrors = 0;
    int          nTests = 0;
    int          nAborts = 0;

    // ==========================================================
    // Clock and abort pulse counter
    always #5 clk = ~clk;
    always @(posedge clk) if (abortOps === 1'b1) nAborts <= nAborts + 1;

    flash_host_model HOST (.clk(clk), .rst_b(rst_b), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    qmode_ctrl DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fourLineMode(fourLineMode),
        .abortOps(abortOps), .volSettings(volSettings));

    // ==========================================================
    // Shared tasks
    task automatic giveVerdict();
        $display("Comparisons %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : giveVerdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Bounded wait on the model; one spare edge lets outputs settle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
        if (done !== 1'b1) begin
            nErrors++;
            giveVerdict();
        end
        @(posedge clk);
    endtask : xfer

    // ==========================================================
    // Scenarios
    task automatic defaults();
        xfer(1'b0, ADDR_VOL, 32'h0);
        check("vol", rdata, 32'h0007_0000);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        check("status", rdata, 32'h0);
        check("mode", fourLineMode, 32'h0);
    endtask : defaults

    task automatic modeSwitch();
        xfer(1'b1, ADDR_CMD, OP_ENTER_4L);
        check("enterNoQe", fourLineMode, 32'h0);
        xfer(1'b1, ADDR_CFG, 32'h1);
        xfer(1'b1, ADDR_VOL, 32'h001D_0015);
        xfer(1'b1, ADDR_CMD, OP_ENTER_4L);
        check("enterQe", fourLineMode, 32'h1);
        xfer(1'b1, ADDR_CMD, OP_EXIT_4L);
        check("exit", fourLineMode, 32'h0);
        check("keep", volSettings, 32'h001D_0015);
    endtask : modeSwitch

    task automatic armBroken();
        xfer(1'b1, ADDR_CMD, OP_ARM);
        xfer(1'b1, ADDR_CMD, OP_EXIT_4L);
        xfer(1'b1, ADDR_CMD, OP_EXEC);
        check("noAbort", nAborts, 32'h0);
        check("noClear", volSettings, 32'h001D_0015);
    endtask : armBroken

    task automatic softReset();
        xfer(1'b1, ADDR_CMD, OP_ENTER_4L);
        xfer(1'b1, ADDR_VOL, 32'hA51F_FFFF);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        check("preStatus", rdata, 32'h1);
        xfer(1'b1, ADDR_CMD, OP_ARM);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        check("armed", rdata, 32'h3);
        xfer(1'b1, ADDR_CMD, OP_EXEC);
        check("abort", nAborts, 32'h1);
        check("modeDefault", fourLineMode, 32'h0);
        check("volClear", volSettings, 32'h0007_0000);
    endtask : softReset

    task automatic recovery();
        int polls;
        xfer(1'b0, ADDR_STATUS, 32'h0);
        check("recovering", rdata, 32'h4);
        xfer(1'b1, ADDR_CMD, OP_ENTER_4L);
        xfer(1'b1, ADDR_VOL, 32'h0000_00FF);
        check("ignored", {fourLineMode, volSettings[30:0]}, 32'h0007_0000);
        xfer(1'b0, ADDR_CMD, 32'h0);
        check("lastOp", rdata, {24'h000000, OP_EXEC});
        xfer(1'b0, ADDR_CFG, 32'h0);
        check("qeKept", rdata, 32'h1);
        polls = 0;
        do begin
            xfer(1'b0, ADDR_STATUS, 32'h0);
            polls++;
        end while (polls < 1000 && rdata[ST_RECOVER] !== 1'b0);
        if (rdata[ST_RECOVER] !== 1'b0) begin
            nErrors++;
            giveVerdict();
        end
        // Six cycles per poll: 3000 recovery cycles less the transfers already made
        check("recoverLen", (polls >= 493 && polls <= 498), 32'h1);
        check("disarmed", rdata, 32'h0);
        xfer(1'b1, ADDR_CMD, OP_ENTER_4L);
        check("accepted", fourLineMode, 32'h1);
    endtask : recovery

    // Reset pair issued in serial mode after leaving four-line mode
    task automatic serialReset();
        xfer(1'b1, ADDR_CMD, OP_EXIT_4L);
        check("serialMode", fourLineMode, 32'h0);
        xfer(1'b1, ADDR_VOL, 32'h0008_00FF);
        xfer(1'b1, ADDR_CMD, OP_ARM);
        xfer(1'b1, ADDR_CMD, OP_EXEC);
        check("serialAbort", nAborts, 32'h2);
        check("serialClear", volSettings, 32'h0007_0000);
    endtask : serialReset

    task automatic unmapped();
        xfer(1'b0, 8'h10, 32'h0);
        check("slverr", {err, rdata[30:0]}, 32'h8000_0000);
    endtask : unmapped

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (PUW_CYCLES) @(posedge clk);
        defaults();
        modeSwitch();
        armBroken();
        softReset();
        recovery();
        serialReset();
        unmapped();
        giveVerdict();
    end
endmodule : quad_mode_exit_and_soft_reset_tb_top
